/* rtl/peripheral_clock_gating.v */
// Peripheral clock gating block with AXI4-Lite register access.
// Functional notes
// - Clearing a function enable stops the module; its register strobes still pass.
// - A set gate bit stops the module's clock entirely.
// - While gated, module register writes are blocked and reads flagged invalid.
// - Gate registers are 8-bit read/write, implemented bits reset to zero.
// - Gate bit one gates the module off; zero leaves it clocked.
// - Capture register: bit 7 unit10, bit 6 unit9, bits 5..1 units 8..4, bit 0 timer12.
// - Comparator register: bit 7 timer10, 6 timer8, 5..3 timers 7..5, 2..0 comparators 3..1.
// - Low register: bit 6 charge-time unit, bit 5 calendar, bits 4..1 timers 4..1.
// - Bits 7 and 0 of the low register are unimplemented and read zero.
// - Calendar gate accepts a one only right after the unlock write sequence.
// - Reduced memory variant drops capture 10, 9, timers 12, 10, 7 and calendar gates.
//
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "clock_gating_defines.vh"

module peripheral_clock_gating #(
	parameter LARGE_MEMORY = 1
) (
	// Clock and reset.
	input wire MCLK_I,
	input wire RESET_N_I,
	// AXI4-Lite write address channel.
	input wire AWVALID,
	output wire AWREADY,
	input wire [7:0] AWADDR,
	input wire [2:0] AWPROT,
	// AXI4-Lite write data channel.
	input wire WVALID,
	output wire WREADY,
	input wire [31:0] WDATA,
	input wire [3:0] WSTRB,
	// AXI4-Lite write response channel.
	output wire BVALID,
	input wire BREADY,
	output wire [1:0] BRESP,
	// AXI4-Lite read address channel.
	input wire ARVALID,
	output wire ARREADY,
	input wire [7:0] ARADDR,
	input wire [2:0] ARPROT,
	// AXI4-Lite read data channel.
	output wire RVALID,
	input wire RREADY,
	output wire [31:0] RDATA,
	output wire [1:0] RRESP,
	// Peripheral side, one slot per gate bit.
	output wire [23:0] PERIPH_CLK_O,
	output wire [23:0] FUNC_RUN_O,
	input wire [23:0] PERIPH_REG_WE_I,
	output wire [23:0] PERIPH_REG_WE_O,
	output wire [23:0] PERIPH_RD_VALID_O
);

	localparam [1:0] UNLOCK_IDLE = 2'h0;
	localparam [1:0] UNLOCK_KEY1 = 2'h1;
	localparam [1:0] UNLOCK_ARMED = 2'h2;

	// Implemented bits per variant.
	wire [7:0] impl_low = LARGE_MEMORY ? `CG_IMPL_TIMERS_LOW_FULL
		: `CG_IMPL_TIMERS_LOW_SMALL;
	wire [7:0] impl_comp = LARGE_MEMORY ? `CG_IMPL_TIMERS_COMP_FULL
		: `CG_IMPL_TIMERS_COMP_SMALL;
	wire [7:0] impl_cap = LARGE_MEMORY ? `CG_IMPL_CAPTURE_HI_FULL
		: `CG_IMPL_CAPTURE_HI_SMALL;
	wire [23:0] impl_mask = {impl_cap, impl_comp, impl_low};

	// Gate registers, clocked by the device clock alone and never gated.
	reg [7:0] gate_low_r;
	reg [7:0] gate_comp_r;
	reg [7:0] gate_cap_r;
	reg [23:0] func_en_r;
	reg [1:0] unlock_r;
	reg [1:0] unlock_nxt;

	// Bus state.
	reg aw_full_r;
	reg [7:0] aw_addr_r;
	reg w_full_r;
	reg [31:0] w_data_r;
	reg [3:0] w_strb_r;
	reg bvalid_r;
	reg [1:0] bresp_r;
	reg rvalid_r;
	reg [31:0] rdata_r;
	reg [1:0] rresp_r;

	wire aw_take = AWVALID && AWREADY;
	wire w_take = WVALID && WREADY;
	wire ar_take = ARVALID && ARREADY;
	wire do_write = aw_full_r && w_full_r && !bvalid_r;

	assign AWREADY = !aw_full_r && !bvalid_r;
	assign WREADY = !w_full_r && !bvalid_r;
	assign BVALID = bvalid_r;
	assign BRESP = bresp_r;
	assign ARREADY = !rvalid_r;
	assign RVALID = rvalid_r;
	assign RDATA = rdata_r;
	assign RRESP = rresp_r;

	wire wr_low = do_write && (aw_addr_r == `CG_ADDR_TIMERS_LOW);
	wire wr_comp = do_write && (aw_addr_r == `CG_ADDR_TIMERS_COMPARATORS);
	wire wr_cap = do_write && (aw_addr_r == `CG_ADDR_CAPTURE_HI);
	wire wr_unlock = do_write && (aw_addr_r == `CG_ADDR_UNLOCK);
	wire wr_func = do_write && (aw_addr_r == `CG_ADDR_FUNC_ENABLE);
	wire wr_mapped = wr_low || wr_comp || wr_cap || wr_unlock || wr_func;
	wire [7:0] wbyte = w_data_r[7:0];
	wire lane0 = w_strb_r[0];

	// Calendar set needs the armed unlock state; clearing is always allowed.
	wire cal_keep = gate_low_r[`CG_CALENDAR_BIT] | (unlock_r == UNLOCK_ARMED);
	reg [7:0] low_wr_val;
	always @* begin
		low_wr_val = wbyte & impl_low;
		low_wr_val[`CG_CALENDAR_BIT] = wbyte[`CG_CALENDAR_BIT] & cal_keep
			& impl_low[`CG_CALENDAR_BIT];
	end

	// Unlock sequence: key1 then key2 on consecutive bus writes; the armed state
	// lasts for exactly the next write, so a stray write in between disarms it.
	always @* begin
		unlock_nxt = unlock_r;
		if (do_write) begin
			case (unlock_r)
				UNLOCK_IDLE: begin
					unlock_nxt = (wr_unlock && lane0 && wbyte == `CG_UNLOCK_KEY1)
						? UNLOCK_KEY1 : UNLOCK_IDLE;
				end
				UNLOCK_KEY1: begin
					if (wr_unlock && lane0 && wbyte == `CG_UNLOCK_KEY2) begin
						unlock_nxt = UNLOCK_ARMED;
					end else if (wr_unlock && lane0 && wbyte == `CG_UNLOCK_KEY1) begin
						unlock_nxt = UNLOCK_KEY1;
					end else begin
						unlock_nxt = UNLOCK_IDLE;
					end
				end
				UNLOCK_ARMED: begin
					unlock_nxt = UNLOCK_IDLE;
				end
				default: begin
					unlock_nxt = UNLOCK_IDLE;
				end
			endcase
		end
	end

	// Register file.
	integer i;
	always @(posedge MCLK_I) begin
		if (!RESET_N_I) begin
			gate_low_r <= `CG_RESET_GATE;
			gate_comp_r <= `CG_RESET_GATE;
			gate_cap_r <= `CG_RESET_GATE;
			func_en_r <= `CG_RESET_FUNC;
			unlock_r <= UNLOCK_IDLE;
		end else begin
			unlock_r <= unlock_nxt;
			if (wr_low && lane0) begin
				gate_low_r <= low_wr_val;
			end
			if (wr_comp && lane0) begin
				gate_comp_r <= wbyte & impl_comp;
			end
			if (wr_cap && lane0) begin
				gate_cap_r <= wbyte & impl_cap;
			end
			if (wr_func) begin
				for (i = 0; i < 3; i = i + 1) begin
					if (w_strb_r[i]) begin
						func_en_r[i*8 +: 8] <= w_data_r[i*8 +: 8] & impl_mask[i*8 +: 8];
					end
				end
			end
		end
	end

	// Write channels are taken independently and answered once both are held.
	always @(posedge MCLK_I) begin
		if (!RESET_N_I) begin
			aw_full_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_full_r <= 1'b0;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= `CG_RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_full_r <= 1'b1;
				aw_addr_r <= {AWADDR[7:2], 2'h0};
			end
			if (w_take) begin
				w_full_r <= 1'b1;
				w_data_r <= WDATA;
				w_strb_r <= WSTRB;
			end
			if (do_write) begin
				aw_full_r <= 1'b0;
				w_full_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= wr_mapped ? `CG_RESP_OKAY : `CG_RESP_SLVERR;
			end else if (bvalid_r && BREADY) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// Gate state as actually applied to the clocks, for status read-back.
	reg [23:0] gate_applied_r;
	wire [23:0] gate_vec = {gate_cap_r, gate_comp_r, gate_low_r} & impl_mask;

	// Read path.
	wire [7:0] ar_word = {ARADDR[7:2], 2'h0};
	reg [31:0] rd_val;
	reg rd_hit;
	always @* begin
		rd_val = 32'h00000000;
		rd_hit = 1'b1;
		case (ar_word)
			`CG_ADDR_TIMERS_LOW: begin
				rd_val = {24'h000000, gate_low_r};
			end
			`CG_ADDR_TIMERS_COMPARATORS: begin
				rd_val = {24'h000000, gate_comp_r};
			end
			`CG_ADDR_CAPTURE_HI: begin
				rd_val = {24'h000000, gate_cap_r};
			end
			`CG_ADDR_UNLOCK: begin
				rd_val = 32'h00000000;
			end
			`CG_ADDR_FUNC_ENABLE: begin
				rd_val = {8'h00, func_en_r};
			end
			`CG_ADDR_GATE_STATUS: begin
				rd_val = {8'h00, gate_applied_r};
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	always @(posedge MCLK_I) begin
		if (!RESET_N_I) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= `CG_RESP_OKAY;
		end else begin
			if (ar_take) begin
				rvalid_r <= 1'b1;
				rdata_r <= rd_val;
				rresp_r <= rd_hit ? `CG_RESP_OKAY : `CG_RESP_SLVERR;
			end else if (rvalid_r && RREADY) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	// Per-slot clock gate. The enable is retimed on the falling edge, so it only
	// changes while the clock is low and the AND can never cut a high phase short.
	// Unimplemented slots get no clock at all, as their module does not exist.
	genvar g;
	generate
		for (g = 0; g < `CG_SLOTS; g = g + 1) begin : slot
			reg run_neg_r;
			always @(negedge MCLK_I) begin
				if (!RESET_N_I) begin
					run_neg_r <= impl_mask[g];
				end else begin
					run_neg_r <= impl_mask[g] & ~gate_vec[g];
				end
			end
			assign PERIPH_CLK_O[g] = MCLK_I & run_neg_r;
			// Register strobes follow only the gate, not the function enable.
			assign PERIPH_REG_WE_O[g] = PERIPH_REG_WE_I[g] & ~gate_vec[g];
			assign PERIPH_RD_VALID_O[g] = impl_mask[g] & ~gate_vec[g];
			assign FUNC_RUN_O[g] = func_en_r[g] & ~gate_vec[g];
		end
	endgenerate

	always @(posedge MCLK_I) begin
		if (!RESET_N_I) begin
			gate_applied_r <= 24'h000000;
		end else begin
			gate_applied_r <= gate_vec;
		end
	end

endmodule // peripheral_clock_gating

/* shared/clock_gating_defines.vh */
// Register map, reset values and field positions of the peripheral clock gating block.
`ifndef CLOCK_GATING_DEFINES_VH
`define CLOCK_GATING_DEFINES_VH

// Byte addresses on the register bus.
`define CG_ADDR_TIMERS_LOW 8'h00
`define CG_ADDR_TIMERS_COMPARATORS 8'h04
`define CG_ADDR_CAPTURE_HI 8'h08
`define CG_ADDR_UNLOCK 8'h0c
`define CG_ADDR_FUNC_ENABLE 8'h10
`define CG_ADDR_GATE_STATUS 8'h14
`define CG_ADDR_W 8

// Reset values.
`define CG_RESET_GATE 8'h00
`define CG_RESET_FUNC 24'h000000

// Implemented bits of each gate register, full and reduced memory variants.
`define CG_IMPL_TIMERS_LOW_FULL 8'h7e
`define CG_IMPL_TIMERS_COMP_FULL 8'hff
`define CG_IMPL_CAPTURE_HI_FULL 8'hff
`define CG_IMPL_TIMERS_LOW_SMALL 8'h5e
`define CG_IMPL_TIMERS_COMP_SMALL 8'h5f
`define CG_IMPL_CAPTURE_HI_SMALL 8'h3e

// Calendar clock gate bit inside the timers_low gate register.
`define CG_CALENDAR_BIT 5

// Unlock sequence keys written to the memory unlock register.
`define CG_UNLOCK_KEY1 8'h55
`define CG_UNLOCK_KEY2 8'haa

// Slot numbering: slot = 8 * register + bit, registers low, comparators, capture.
`define CG_SLOTS 24

// Bus response codes.
`define CG_RESP_OKAY 2'h0
`define CG_RESP_SLVERR 2'h2

`endif

/* sim/peripheral_clock_gating_props.sv */
// Concurrent checks on the ports of the peripheral clock gating block.
`timescale 1ns/1ps
module peripheral_clock_gating_props #(
	parameter LARGE_MEMORY = 1
) (
	// Clock and reset.
	input wire MCLK_I,
	input wire RESET_N_I,
	// Read channel.
	input wire ARVALID,
	input wire ARREADY,
	input wire RVALID,
	input wire RREADY,
	input wire [31:0] RDATA,
	// Peripheral side.
	input wire [23:0] PERIPH_CLK_O,
	input wire [23:0] FUNC_RUN_O,
	input wire [23:0] PERIPH_REG_WE_I,
	input wire [23:0] PERIPH_REG_WE_O,
	input wire [23:0] PERIPH_RD_VALID_O
);
	// Absent slots never gate, so the passed-strobe, gated-run and absent-slot checks are masked with this.
	localparam [23:0] IMPL = LARGE_MEMORY ? 24'hffff7e : 24'h3e5f5e;
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!RESET_N_I);
	property p_gate;
		@(negedge MCLK_I) disable iff (!RESET_N_I) PERIPH_CLK_O == $past(PERIPH_RD_VALID_O);
	endproperty
	a_gate: assert property (p_gate) else $error("gated clock wrong");
	property p_wep; (PERIPH_REG_WE_I & PERIPH_RD_VALID_O & ~PERIPH_REG_WE_O) == 24'h0; endproperty
	a_wep: assert property (p_wep) else $error("strobe lost");
	property p_web; (PERIPH_REG_WE_O & ~PERIPH_RD_VALID_O & IMPL) == 24'h0; endproperty
	a_web: assert property (p_web) else $error("strobe passed gate");
	property p_rung; (FUNC_RUN_O & ~PERIPH_RD_VALID_O & IMPL) == 24'h0; endproperty
	a_rung: assert property (p_rung) else $error("gated slot runs");
	property p_runwe; (PERIPH_REG_WE_I & FUNC_RUN_O & ~PERIPH_REG_WE_O) == 24'h0; endproperty
	a_runwe: assert property (p_runwe) else $error("running slot lost strobe");
	property p_unimp; (PERIPH_RD_VALID_O & ~IMPL) == 24'h0; endproperty
	a_unimp: assert property (p_unimp) else $error("absent slot valid");
	property p_rhold; RVALID && !RREADY |=> RVALID && $stable(RDATA); endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped");
	property p_rans; ARVALID && ARREADY |=> RVALID; endproperty
	a_rans: assert property (p_rans) else $error("no read answer");
endmodule // peripheral_clock_gating_props

bind peripheral_clock_gating peripheral_clock_gating_props
	#(.LARGE_MEMORY(LARGE_MEMORY)) props_u (
	.MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I),
	.ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA),
	.PERIPH_CLK_O(PERIPH_CLK_O), .FUNC_RUN_O(FUNC_RUN_O), .PERIPH_REG_WE_I(PERIPH_REG_WE_I),
	.PERIPH_REG_WE_O(PERIPH_REG_WE_O), .PERIPH_RD_VALID_O(PERIPH_RD_VALID_O)
);

/* sim/periph_model.sv */
// Stand-in for the gated peripherals: each slot counts the clock edges it gets.
`timescale 1ns/1ps
module periph_model (
	// Gated clocks from the gating block.
	input wire logic [23:0] clk_i,
	// Edge count of each slot, eight bits per slot, slot 0 lowest.
	output wire [191:0] ticks_o
);
	for (genvar k = 0; k < 24; k++) begin : g_slot
		logic [7:0] cnt = 8'h00;
		always @(posedge clk_i[k]) cnt <= cnt + 8'h01;
		assign ticks_o[k*8 +: 8] = cnt;
	end
endmodule // periph_model

/* sim/test_peripheral_clock_gating.sv */
// Self-checking bench for the peripheral clock gating block.
`timescale 1ns/1ps
`include "clock_gating_defines.vh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
	$display("wrong value %s exp %h got %h", n, e, g); end end
module test_peripheral_clock_gating;
	logic MCLK_I = 1'h0, RESET_N_I = 1'h0, AWVALID = 1'h0, WVALID = 1'h0;
	logic BREADY = 1'h0, ARVALID = 1'h0, RREADY = 1'h0;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
	logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00, t;
	logic [2:0] AWPROT = 3'h0, ARPROT = 3'h0;
	logic [3:0] WSTRB = 4'hf;
	logic [31:0] WDATA = 32'h0, RDATA;
	logic [1:0] BRESP, RRESP, resp;
	logic [23:0] PERIPH_CLK_O, FUNC_RUN_O, PERIPH_REG_WE_O, PERIPH_RD_VALID_O;
	logic [23:0] PERIPH_REG_WE_I = 24'hffffff;
	logic [191:0] ticks;
	logic [23:0] sm_valid;
	int errors = 0, num_checks = 0;
	peripheral_clock_gating dut_u (
		.MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I),
		.AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR), .AWPROT(AWPROT),
		.WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB),
		.BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
		.ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR), .ARPROT(ARPROT),
		.RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
		.PERIPH_CLK_O(PERIPH_CLK_O), .FUNC_RUN_O(FUNC_RUN_O),
		.PERIPH_REG_WE_I(PERIPH_REG_WE_I), .PERIPH_REG_WE_O(PERIPH_REG_WE_O),
		.PERIPH_RD_VALID_O(PERIPH_RD_VALID_O)
	);
	// Reduced memory variant on the same bus; its answers match in timing, so only
	// its PERIPH_RD_VALID_O output is watched, as sm_valid.
	peripheral_clock_gating #(.LARGE_MEMORY(0)) dut_small_u (
		.MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I),
		.AWVALID(AWVALID), .AWREADY(), .AWADDR(AWADDR), .AWPROT(AWPROT),
		.WVALID(WVALID), .WREADY(), .WDATA(WDATA), .WSTRB(WSTRB),
		.BVALID(), .BREADY(BREADY), .BRESP(),
		.ARVALID(ARVALID), .ARREADY(), .ARADDR(ARADDR), .ARPROT(ARPROT),
		.RVALID(), .RREADY(RREADY), .RDATA(), .RRESP(),
		.PERIPH_CLK_O(), .FUNC_RUN_O(),
		.PERIPH_REG_WE_I(PERIPH_REG_WE_I), .PERIPH_REG_WE_O(),
		.PERIPH_RD_VALID_O(sm_valid)
	);
	periph_model model_u (.clk_i(PERIPH_CLK_O), .ticks_o(ticks));
	always #12.5 MCLK_I = ~MCLK_I;
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge MCLK_I);
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'h1;
		WVALID <= 1'h1;
		BREADY <= 1'h1;
		do begin
			@(posedge MCLK_I);
			n++;
			if (AWREADY) AWVALID <= 1'h0;
			if (WREADY) WVALID <= 1'h0;
		end while (!BVALID && n < 40);
		// Bready stood high, so the edge that shows bvalid is the handshake.
		BREADY <= 1'h0;
		resp = BRESP;
		if (!BVALID) tmo;
	endtask
	// Rready is offered with the address, so the answer is taken at its first edge.
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		int n;
		logic [31:0] q;
		n = 0;
		@(posedge MCLK_I);
		ARADDR <= a;
		ARVALID <= 1'h1;
		RREADY <= 1'h1;
		do begin
			@(posedge MCLK_I);
			n++;
			if (ARREADY) ARVALID <= 1'h0;
		end while (!RVALID && n < 40);
		RREADY <= 1'h0;
		resp = RRESP;
		q = RDATA;
		`CHK("rdata", e, q)
		if (!RVALID) tmo;
	endtask
	task automatic ticks_run(input int k, input logic [7:0] e);
		@(negedge MCLK_I);
		t = ticks[k*8 +: 8];
		repeat (4) @(negedge MCLK_I);
		`CHK("ticks", e, 8'(ticks[k*8 +: 8] - t))
	endtask
	task t_gate;
		logic [7:0] g;
		for (int r = 0; r < 3; r++) begin
			g = (r == 0) ? 8'h5e : 8'hff;
			rd(8'(4 * r), 32'h0);
			wr(8'(4 * r), 32'hff);
			rd(8'(4 * r), {24'h0, g});
			`CHK("valid", 24'hffff7e & ~(24'(g) << 8 * r), PERIPH_RD_VALID_O)
			`CHK("we", ~(24'(g) << 8 * r), PERIPH_REG_WE_O)
			`CHK("small valid", 24'h3e5f5e & ~(24'hff << 8 * r), sm_valid)
			rd(`CG_ADDR_GATE_STATUS, {8'h00, 24'(g) << 8 * r});
			ticks_run(8 * r + 1, 8'h00);
			wr(8'(4 * r), 32'h0);
			ticks_run(8 * r + 1, 8'h04);
		end
		$display("gate map done");
	endtask
	task t_unlock;
		wr(8'h00, 32'h20);
		rd(8'h00, 32'h0);
		wr(8'h0c, 32'h55);
		wr(8'h0c, 32'haa);
		wr(8'h00, 32'h20);
		rd(8'h00, 32'h20);
		`CHK("valid", 24'hffff5e, PERIPH_RD_VALID_O)
		`CHK("small valid", 24'h3e5f5e, sm_valid)
		wr(8'h00, 32'h0);
		rd(8'h00, 32'h0);
		wr(8'h0c, 32'h55);
		wr(8'h0c, 32'haa);
		wr(8'h08, 32'h0);
		wr(8'h00, 32'h20);
		rd(8'h00, 32'h0);
		rd(8'h0c, 32'h0);
		wr(8'h40, 32'h1);
		`CHK("bresp", `CG_RESP_SLVERR, resp)
		rd(8'h40, 32'h0);
		`CHK("rresp", `CG_RESP_SLVERR, resp)
		$display("unlock done");
	endtask
	task t_func;
		wr(8'h10, 32'h2);
		`CHK("run", 24'h2, FUNC_RUN_O)
		`CHK("we", 24'hffffff, PERIPH_REG_WE_O)
		wr(8'h00, 32'h2);
		`CHK("run", 24'h0, FUNC_RUN_O)
		PERIPH_REG_WE_I <= 24'h00000f;
		@(negedge MCLK_I);
		`CHK("we", 24'h00000d, PERIPH_REG_WE_O)
		rd(8'h00, 32'h2);
		rd(8'h10, 32'h2);
		WSTRB <= 4'h0;
		wr(8'h00, 32'h0);
		WSTRB <= 4'hf;
		rd(8'h00, 32'h2);
		$display("function enable done");
	endtask
	// A second reset in mid-run must bring every gate and enable back to zero.
	task t_reset;
		RESET_N_I <= 1'h0;
		repeat (3) @(posedge MCLK_I);
		RESET_N_I <= 1'h1;
		rd(8'h00, 32'h0);
		rd(8'h10, 32'h0);
		`CHK("run", 24'h0, FUNC_RUN_O)
		`CHK("valid", 24'hffff7e, PERIPH_RD_VALID_O)
		`CHK("small valid", 24'h3e5f5e, sm_valid)
		$display("reset done");
	endtask
	task tmo;
		errors++;
		tally_and_finish;
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge MCLK_I);
		RESET_N_I <= 1'h1;
		t_gate;
		t_unlock;
		t_func;
		t_reset;
		tally_and_finish;
	end
endmodule // test_peripheral_clock_gating
